// >>> tmc_timer.sv
// 16-bit match timer/counter with timer, event and window modes
// Function
// - Old compare value stays in use until the high byte completes the pair.
// - Control read returns bits 7, 6 and 1 without meaning.
// - Source code 100 gives the undivided main clock, timer mode in slow two.
// - Entering stop mode clears run control; software restarts after release.
// - Codes 000 to 011 pick divided clocks; 100 main, 101 sub; 110 reserved; 111 the pin.
// - Timer mode counts internal ticks; on match interrupt, clear and continue.
// - Main clock in slow two matches on upper five compare bits only.
// - Timer mode on main or sub clock can time oscillator warm-up.
// - Event mode counts pin rising edges, resuming after each clear.
// - Event mode match is checked and signalled at the pin falling edge.
// - Window mode counts internal ticks only while pin is high.
// - Three behaviours: timing, edge counting, gated window counting.
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module tmc_timer (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic        count_input_pin_in,
  input  wire logic        sub_osc_clock_in,
  output logic             wb_ack_out,
  output logic [31:0]      wb_dat_out,
  output logic             match_interrupt_out
);

  typedef struct packed {
    logic                 run;
    logic [2:0]           clk_src;
    logic                 window;
    logic [15:0]          cmp;
    logic                 low_pending;
    logic [7:0]           low_hold;
    logic [15:0]          cnt;
    tmc_pkg::tmc_pmode_t  pmode;
    logic                 tap_sel;
    logic [22:0]          main_div;
    logic [14:0]          sub_div;
    logic                 ack;
    logic [31:0]          rdat;
    logic                 irq;
  } tmc_state_t;

  tmc_state_t          state;
  tmc_state_t          next_state;
  tmc_pkg::tmc_wb_req_t req;
  tmc_pkg::tmc_edge_t   pin;
  tmc_pkg::tmc_edge_t   sub;

  logic        tick;
  logic        warm;
  logic        bus_write;
  logic        bus_read;
  logic [15:0] inc;
  logic [7:0]  ctrl_rd;

  tmc_sync_edge u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (count_input_pin_in),
    .edge_out   (pin)
  );

  tmc_sync_edge u_sub_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (sub_osc_clock_in),
    .edge_out   (sub)
  );

  // True when the low n bits of a divider are all ones
  function automatic logic div_tick(input logic [22:0] div, input int n);
    logic [22:0] mask;
    mask = 23'((33'h1 << n) - 33'h1);
    div_tick = ((div & mask) == mask);
  endfunction : div_tick

  // Compare, optionally on the upper five bits only
  function automatic logic is_match(input logic [15:0] cnt, input logic [15:0] cmp,
                                    input logic upper_only);
    if (upper_only)
      is_match = (cnt[15:tmc_pkg::WARM_LSB] == cmp[15:tmc_pkg::WARM_LSB]);
    else
      is_match = (cnt == cmp);
  endfunction : is_match

  // Tick of the selected internal source for the present power mode
  function automatic logic src_tick(input logic [2:0] src, input tmc_pkg::tmc_pmode_t pm,
                                    input logic tap, input logic [22:0] mdiv,
                                    input logic [14:0] sdiv, input logic srise);
    logic        low_speed;
    logic [22:0] sx;
    low_speed = (pm != tmc_pkg::PM_NORMAL);
    sx        = {8'h00, sdiv};
    src_tick  = 1'b0;
    unique case (tmc_pkg::tmc_clk_src_t'(src))
      tmc_pkg::CK_DIV_A:
        if (low_speed || tap)
          src_tick = srise & div_tick(sx, tmc_pkg::FS_TAP_15);
        else
          src_tick = div_tick(mdiv, tmc_pkg::FC_TAP_23);
      tmc_pkg::CK_DIV_B:
        if (low_speed || tap)
          src_tick = srise & div_tick(sx, tmc_pkg::FS_TAP_5);
        else
          src_tick = div_tick(mdiv, tmc_pkg::FC_TAP_13);
      tmc_pkg::CK_DIV_C:
        src_tick = ~low_speed & div_tick(mdiv, tmc_pkg::FC_TAP_8);
      tmc_pkg::CK_DIV_D:
        src_tick = ~low_speed & div_tick(mdiv, tmc_pkg::FC_TAP_3);
      tmc_pkg::CK_MAIN:
        src_tick = (pm == tmc_pkg::PM_LOW_SPEED_MODE_TWO);
      tmc_pkg::CK_SUB:
        src_tick = ~low_speed & srise;
      tmc_pkg::CK_RESV:
        src_tick = 1'b0;
      tmc_pkg::CK_PIN:
        src_tick = 1'b0;
    endcase
  endfunction : src_tick

  always_comb
  begin
    req.cyc = wb_cyc_in;
    req.stb = wb_stb_in;
    req.we  = wb_we_in;
    req.adr = wb_adr_in;
    req.sel = wb_sel_in;
    req.dat = wb_dat_in;
  end

  always_comb
  begin
    next_state = state;
    next_state.irq = 1'b0;
    next_state.main_div = state.main_div + 23'h1;
    if (sub.rise)
      next_state.sub_div = state.sub_div + 15'h1;

    // Undivided main clock in slow two: upper bits only
    warm = (state.clk_src == tmc_pkg::CK_MAIN) && (state.pmode == tmc_pkg::PM_LOW_SPEED_MODE_TWO)
           && !state.window;
    tick = src_tick(state.clk_src, state.pmode, state.tap_sel,
                    state.main_div, state.sub_div, sub.rise);
    inc  = state.cnt + 16'h1;

    ctrl_rd = 8'h00;
    ctrl_rd[tmc_pkg::CTL_RUN_BIT] = state.run;
    ctrl_rd[tmc_pkg::CTL_CK_LSB +: 3] = state.clk_src;
    ctrl_rd[tmc_pkg::CTL_MODE_BIT] = state.window;

    bus_read  = req.cyc && req.stb && !state.ack;
    bus_write = req.cyc && req.stb && req.we && state.ack && req.sel[0];

    // Classic slave: ack one cycle after the strobe, dropped next cycle
    next_state.ack = bus_read;
    if (bus_read)
    begin
      next_state.rdat = 32'h0000_0000;
      unique case (req.adr)
        tmc_pkg::OFS_CONTROL:  next_state.rdat = {24'h000000, ctrl_rd};
        tmc_pkg::OFS_CMP_LOW:  next_state.rdat = {24'h000000, state.cmp[7:0]};
        tmc_pkg::OFS_CMP_HIGH: next_state.rdat = {24'h000000, state.cmp[15:8]};
        tmc_pkg::OFS_COUNT:    next_state.rdat = {16'h0000, state.cnt};
        tmc_pkg::OFS_SYSTEM:   next_state.rdat = {29'h0, state.tap_sel, state.pmode};
        default:               next_state.rdat = 32'h0000_0000;
      endcase
    end

    // Counting
    if (!state.run)
      next_state.cnt = 16'h0000;
    else if (state.clk_src == tmc_pkg::CK_PIN && !state.window)
    begin
      if (pin.rise)
        next_state.cnt = inc;
      else if (pin.fall && is_match(state.cnt, state.cmp, 1'b0))
      begin
        next_state.cnt = 16'h0000;
        next_state.irq = 1'b1;
      end
    end
    else if (tick && (!state.window || (pin.level && state.pmode == tmc_pkg::PM_NORMAL)))
    begin
      // Window gating or plain timing on the internal tick
      if (is_match(inc, state.cmp, warm))
      begin
        next_state.cnt = 16'h0000;
        next_state.irq = 1'b1;
      end
      else
        next_state.cnt = inc;
    end

    // Register writes take effect at the acknowledged edge
    if (bus_write)
    begin
      unique case (req.adr)
        tmc_pkg::OFS_CONTROL:
        begin
          next_state.run     = req.dat[tmc_pkg::CTL_RUN_BIT];
          next_state.clk_src = req.dat[tmc_pkg::CTL_CK_LSB +: 3];
          next_state.window  = req.dat[tmc_pkg::CTL_MODE_BIT];
        end
        tmc_pkg::OFS_CMP_LOW:
        begin
          next_state.low_hold    = req.dat[7:0];
          next_state.low_pending = 1'b1;
        end
        tmc_pkg::OFS_CMP_HIGH:
        begin
          if (state.low_pending)
          begin
            next_state.cmp         = {req.dat[7:0], state.low_hold};
            next_state.low_pending = 1'b0;
          end
          else if (warm)
            next_state.cmp[15:8] = req.dat[7:0];
        end
        tmc_pkg::OFS_SYSTEM:
        begin
          next_state.pmode   = tmc_pkg::tmc_pmode_t'(req.dat[tmc_pkg::SYS_PMODE_LSB +: 2]);
          next_state.tap_sel = req.dat[tmc_pkg::SYS_TAP_BIT];
          if (req.dat[tmc_pkg::SYS_STOP_BIT])
            next_state.run = 1'b0;
        end
        default:
        begin
          next_state.run = next_state.run;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state         <= '0;
      state.clk_src <= tmc_pkg::CK_RESET;
      state.cmp     <= tmc_pkg::CMP_RESET;
      state.pmode   <= tmc_pkg::tmc_pmode_t'(tmc_pkg::PM_RESET);
    end
    else
      state <= next_state;
  end

  always_comb
  begin
    wb_ack_out          = state.ack;
    wb_dat_out          = state.rdat;
    match_interrupt_out = state.irq;
  end

endmodule : tmc_timer

// >>> tmc_pkg.sv
// Package for the 16-bit match window timer: offsets, fields, reset values, types
package tmc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_CMP_LOW   = 8'h04;
  localparam logic [7:0] OFS_CMP_HIGH  = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0c;
  localparam logic [7:0] OFS_SYSTEM    = 8'h10;

  // Control register field positions
  localparam int CTL_MODE_BIT = 0;
  localparam int CTL_CK_LSB   = 2;
  localparam int CTL_RUN_BIT  = 5;

  // System register field positions
  localparam int SYS_PMODE_LSB = 0;
  localparam int SYS_TAP_BIT   = 2;
  localparam int SYS_STOP_BIT  = 3;

  // Reset values
  localparam logic [15:0] CMP_RESET  = 16'h0000;
  localparam logic [2:0]  CK_RESET   = 3'h0;
  localparam logic [1:0]  PM_RESET   = 2'h0;

  // Divider taps, as powers of two
  localparam int FC_TAP_23 = 23;
  localparam int FC_TAP_13 = 13;
  localparam int FC_TAP_8  = 8;
  localparam int FC_TAP_3  = 3;
  localparam int FS_TAP_15 = 15;
  localparam int FS_TAP_5  = 5;

  // Upper compare bits used for warm-up matching
  localparam int WARM_LSB = 11;

  // Clock source codes
  typedef enum logic [2:0] {
    CK_DIV_A   = 3'h0,
    CK_DIV_B   = 3'h1,
    CK_DIV_C   = 3'h2,
    CK_DIV_D   = 3'h3,
    CK_MAIN    = 3'h4,
    CK_SUB     = 3'h5,
    CK_RESV    = 3'h6,
    CK_PIN     = 3'h7
  } tmc_clk_src_t;

  // Power modes, Gray ordered
  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_LOW_SPEED_MODE_ONE  = 2'h1,
    PM_LOW_SPEED_MODE_TWO  = 2'h3,
    PM_SLEEP  = 2'h2
  } tmc_pmode_t;

  // Classic Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmc_wb_req_t;

  // Edge detector outputs
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tmc_edge_t;

endpackage : tmc_pkg

// >>> tmc_sync_edge.sv
// Two-flop synchroniser with edge detection for an outside pin
`timescale 1ns/1ps
module tmc_sync_edge (
  input  wire logic           clk_sys_in,
  input  wire logic           sys_rst_in,
  input  wire logic           pin_in,
  output tmc_pkg::tmc_edge_t  edge_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tmc_sync_state_t;

  tmc_sync_state_t state;
  tmc_sync_state_t next_state;

  always_comb
  begin
    next_state      = state;
    next_state.meta = pin_in;
    next_state.sync = state.meta;
    next_state.last = state.sync;
    edge_out.level  = state.sync;
    edge_out.rise   = state.sync & ~state.last;
    edge_out.fall   = ~state.sync & state.last;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      state <= '0;
    else
      state <= next_state;
  end

endmodule : tmc_sync_edge

// >>> tmc_timer_monitor.sv
// Checker for the match timer bus answers and interrupt pulses
`timescale 1ns/1ps
module tmc_timer_monitor (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic        match_interrupt_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic run_q;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = wb_ack_out && wb_we_in && wb_sel_in[0];
  assign rd_ok = wb_ack_out && !wb_we_in;
  // Shadow of the run bit as software left it
  always_ff @(posedge clk_sys_in)
    if (sys_rst_in)
      run_q <= 1'b0;
    else if (wr_ok && wb_adr_in == tmc_pkg::OFS_CONTROL)
      run_q <= wb_dat_in[tmc_pkg::CTL_RUN_BIT];
    else if (wr_ok && wb_adr_in == tmc_pkg::OFS_SYSTEM && wb_dat_in[tmc_pkg::SYS_STOP_BIT])
      run_q <= 1'b0;
  chk_ack_follows: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without request");
  chk_rst_quiet: assert property ($fell(sys_rst_in) |-> !wb_ack_out && !match_interrupt_out)
    else $error("outputs active after reset");
  chk_irq_pulse: assert property (match_interrupt_out |=> !match_interrupt_out)
    else $error("interrupt longer than one cycle");
  chk_ctl_read: assert property (rd_ok && wb_adr_in == tmc_pkg::OFS_CONTROL |->
    wb_dat_out[7:6] == 2'h0 && !wb_dat_out[1])
    else $error("control unused bits not zero");
  chk_unmapped_zero: assert property (rd_ok && wb_adr_in == 8'h14 |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  chk_count_idle: assert property (rd_ok && wb_adr_in == tmc_pkg::OFS_COUNT && !run_q &&
    !$past(run_q, 3) |-> wb_dat_out == 32'h0)
    else $error("counter not zero while stopped");
  chk_irq_stopped: assert property (!run_q && !$past(run_q, 3) |-> !match_interrupt_out)
    else $error("interrupt while stopped");
endmodule : tmc_timer_monitor

// >>> tmc_pin_model.sv
// Outside pin source and free running sub oscillator
`timescale 1ns/1ps
module tmc_pin_model (
  input  wire logic clk_sys_in,
  output logic      pin_out,
  output logic      sub_clk_out
);
  logic [3:0] div = 4'h0;
  initial pin_out = 1'b0;
  initial sub_clk_out = 1'b0;
  // Sub oscillator runs free, 32 system clocks a period
  always @(posedge clk_sys_in)
  begin
    div <= div + 4'h1;
    if (div == 4'hf)
      sub_clk_out <= ~sub_clk_out;
  end
  // Each level held at least one machine cycle pair
  task automatic put(input logic lvl, input int hold);
    @(posedge clk_sys_in);
    pin_out <= lvl;
    repeat ((hold < 8) ? 8 : hold) @(posedge clk_sys_in);
  endtask : put
endmodule : tmc_pin_model

// >>> tb.sv
// Self-checking bench for the match timer
`timescale 1ns/1ps
module tb;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        ack;
  logic [31:0] rdat;
  logic        irq;
  logic        pin;
  logic        sub_clk;
  logic [31:0] q;
  logic [31:0] q2;
  int          errors = 0;
  int          n_compared = 0;
  int          n_irq = 0;
  int          base;
  int          gap;
  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
    if (irq === 1'b1)
      n_irq <= n_irq + 1;
  tmc_timer u_tmc_timer (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .count_input_pin_in(pin), .sub_osc_clock_in(sub_clk), .wb_ack_out(ack),
    .wb_dat_out(rdat), .match_interrupt_out(irq));
  tmc_pin_model u_tmc_pin_model (.clk_sys_in(clk_sys_in), .pin_out(pin), .sub_clk_out(sub_clk));
  task automatic wrap_up;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    // Ack sampled at the rising edge; write lands and read data is taken there
    @(posedge clk_sys_in);
    while (ack !== 1'b1 && i < 20)
    begin
      @(posedge clk_sys_in);
      i++;
    end
    if (ack !== 1'b1)
    begin
      check({31'h0, ack}, 32'h1);
      wrap_up();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rd
  task automatic wait_irq(output int n);
    int b;
    b = n_irq;
    n = 0;
    while (n_irq == b && n < 5000)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n_irq == b)
    begin
      check(n_irq, b + 1);
      wrap_up();
    end
  endtask : wait_irq
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(tmc_pkg::OFS_CONTROL, 32'h0);
    rd(tmc_pkg::OFS_CMP_HIGH, 32'h0);
    bus(1'b1, tmc_pkg::OFS_CMP_LOW, 32'h34);
    rd(tmc_pkg::OFS_CMP_LOW, 32'h0);
    bus(1'b1, tmc_pkg::OFS_CMP_HIGH, 32'h12);
    rd(tmc_pkg::OFS_CMP_LOW, 32'h34);
    rd(tmc_pkg::OFS_CMP_HIGH, 32'h12);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'hdf);
    rd(tmc_pkg::OFS_CONTROL, 32'h1d);
    rd(8'h14, 32'h0);
    // Timer on fc/8 with compare 3
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h0c);
    bus(1'b1, tmc_pkg::OFS_CMP_LOW, 32'h03);
    bus(1'b1, tmc_pkg::OFS_CMP_HIGH, 32'h00);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h2c);
    wait_irq(gap);
    wait_irq(gap);
    check(gap, 24);
    bus(1'b1, tmc_pkg::OFS_SYSTEM, 32'h08);
    rd(tmc_pkg::OFS_CONTROL, 32'h0c);
    base = n_irq;
    repeat (60) @(posedge clk_sys_in);
    check(n_irq, base);
    rd(tmc_pkg::OFS_COUNT, 32'h0);
    // Pin edge counting
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h1c);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h3c);
    repeat (2)
    begin
      u_tmc_pin_model.put(1'b1, 10);
      u_tmc_pin_model.put(1'b0, 10);
    end
    rd(tmc_pkg::OFS_COUNT, 32'h2);
    u_tmc_pin_model.put(1'b1, 12);
    rd(tmc_pkg::OFS_COUNT, 32'h3);
    check(n_irq, base);
    u_tmc_pin_model.put(1'b0, 10);
    check(n_irq, base + 1);
    rd(tmc_pkg::OFS_COUNT, 32'h0);
    // Gated counting on fc/8, compare 0x0100
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h1c);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h0d);
    bus(1'b1, tmc_pkg::OFS_CMP_LOW, 32'h00);
    bus(1'b1, tmc_pkg::OFS_CMP_HIGH, 32'h01);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h2d);
    u_tmc_pin_model.put(1'b0, 40);
    rd(tmc_pkg::OFS_COUNT, 32'h0);
    u_tmc_pin_model.put(1'b1, 40);
    u_tmc_pin_model.put(1'b0, 8);
    bus(1'b0, tmc_pkg::OFS_COUNT, 32'h0);
    q2 = q;
    check({31'h0, q2 >= 32'h4 && q2 <= 32'h6}, 32'h1);
    rd(tmc_pkg::OFS_COUNT, q2);
    // Warm-up timing on the undivided main clock in slow two
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h0d);
    bus(1'b1, tmc_pkg::OFS_SYSTEM, 32'h03);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h10);
    bus(1'b1, tmc_pkg::OFS_CMP_HIGH, 32'h10);
    rd(tmc_pkg::OFS_CMP_HIGH, 32'h10);
    rd(tmc_pkg::OFS_CMP_LOW, 32'h00);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h30);
    wait_irq(gap);
    wait_irq(gap);
    check(gap, 4096);
    // Reserved source never counts
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h10);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h18);
    bus(1'b1, tmc_pkg::OFS_CONTROL, 32'h38);
    repeat (60) @(posedge clk_sys_in);
    rd(tmc_pkg::OFS_COUNT, 32'h0);
    wrap_up();
  end
endmodule : tb
bind tmc_timer tmc_timer_monitor u_mon (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out), .match_interrupt_out(match_interrupt_out));
